// File: common/sirf_pkg.sv
// Behaviour
// - Drop unknown multicast when filter bit set
// - Drop unknown unicast when drop bit set
// - IPv4 queue from precedence or DIFFSERV table
// - Tag priority beats IP when enabled
// - VLAN rules only while VLAN enable set
// - Learn source when enabled and forwarding/learning
// - Drop when ingress port not VLAN member
// - Admit-non-member bit skips ingress membership drop
// - Known destination: egress must also be member
// - Membership and tagged-only need VLAN enable
// - Tagged-only ports drop untagged and priority-tagged
// - Per-port bit groups: MSB port 2, LSB port 0
// - Two-bit spanning tree state, reset forwarding
// - IP priority source only when IP bit set
// - Tag priority source only when tag bit set
// - DIFFSERV entry holds three-bit priority, indexed
package sirf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam logic [15:0] SIRF_IDX_GLOBAL     = 16'h1840;
  localparam logic [15:0] SIRF_IDX_PORT_CFG   = 16'h1841;
  localparam logic [15:0] SIRF_IDX_TAG_ONLY   = 16'h1842;
  localparam logic [15:0] SIRF_IDX_PORT_STATE = 16'h1843;
  localparam logic [15:0] SIRF_IDX_NON_MEMBER = 16'h1844;
  localparam logic [15:0] SIRF_IDX_DS_INDEX   = 16'h1811;
  localparam logic [15:0] SIRF_IDX_DS_WDATA   = 16'h1812;
  localparam logic [15:0] SIRF_IDX_DS_RDATA   = 16'h1813;

  ////////////////////////////////////////////////////////////////////////////
  // Global configuration field positions
  localparam int SIRF_G_VLAN_EN   = 0;
  localparam int SIRF_G_TAG_OV_IP = 1;
  localparam int SIRF_G_USE_PREC  = 2;
  localparam int SIRF_G_DROP_UNK  = 3;
  localparam int SIRF_G_FILT_MC   = 4;
  localparam int SIRF_G_IP_PRIORITY_ENABLE    = 9;
  localparam int SIRF_G_USE_TAG   = 14;
  localparam int SIRF_G_WIDTH     = 15;

  // Port configuration field positions
  localparam int SIRF_P_MEMB_LSB  = 0;
  localparam int SIRF_P_LEARN_LSB = 3;

  // Reset values
  localparam logic [14:0] SIRF_G_RST      = 15'h0006;
  localparam logic [5:0]  SIRF_P_RST      = 6'h38;
  localparam logic [2:0]  SIRF_TAGO_RST   = 3'h0;
  localparam logic [5:0]  SIRF_STATE_RST  = 6'h00;
  localparam logic [2:0]  SIRF_NMEMB_RST  = 3'h0;
  localparam logic [2:0]  SIRF_DS_RST     = 3'h0;

  // Sizes
  localparam int SIRF_PORTS    = 3;
  localparam int SIRF_DS_DEPTH = 64;

  ////////////////////////////////////////////////////////////////////////////
  // Spanning tree states, codes as stored in the register
  localparam logic [1:0] SIRF_ST_FWD   = 2'h0;
  localparam logic [1:0] SIRF_ST_BLOCK = 2'h1;
  localparam logic [1:0] SIRF_ST_LEARN = 2'h2;
  localparam logic [1:0] SIRF_ST_DIS   = 2'h3;

  // Priority source chosen for the transmit queue
  typedef enum logic [2:0] {
    SIRF_SRC_DEFAULT,
    SIRF_SRC_TAG,
    SIRF_SRC_PREC,
    SIRF_SRC_DIFFSERV,
    SIRF_SRC_IPV6
  } sirf_src_t;

endpackage : sirf_pkg

// File: dv/sirf_filter_properties.sv
`timescale 1ns/1ps
// Shadows the configuration and checks decisions against it
module sirf_filter_properties
  import sirf_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        nrst_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic        pkt_valid_i,
  input wire logic [1:0]  pkt_port_i,
  input wire logic        pkt_da_mc_i,
  input wire logic        pkt_da_bc_i,
  input wire logic        pkt_da_found_i,
  input wire logic        dec_valid_o,
  input wire logic        dec_drop_o,
  input wire logic        dec_learn_o,
  input wire logic [2:0]  dec_src_o
);
  logic [14:0] glob_q; // Global config shadow
  logic [5:0]  pcfg_q; // Port config shadow
  logic [5:0]  st_q;   // Port state shadow
  logic [1:0]  pi_w;   // Port index; code 3 folds onto port 0
  logic [1:0]  st_w;   // State of the ingress port
  logic        lrn_w;  // Expected learn decision
  //////////////////////////////////////////////////////////////////////////
  // Shadows follow writes so a change is seen from the next descriptor on
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
    begin
      glob_q <= SIRF_G_RST;
      pcfg_q <= SIRF_P_RST;
      st_q   <= SIRF_STATE_RST;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == SIRF_IDX_GLOBAL) glob_q <= reg_wdata_i[14:0];
      if (reg_addr_i == SIRF_IDX_PORT_CFG) pcfg_q <= reg_wdata_i[5:0];
      if (reg_addr_i == SIRF_IDX_PORT_STATE) st_q <= reg_wdata_i[5:0];
    end
  assign pi_w  = (pkt_port_i == 2'h3) ? 2'h0 : pkt_port_i;
  assign st_w  = st_q[{pi_w, 1'b0} +: 2];
  assign lrn_w = pcfg_q[3 + pi_w] &&
                 (st_w == SIRF_ST_FWD || st_w == SIRF_ST_LEARN);
  //////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  dec_valid_a: assert property (pkt_valid_i |=> dec_valid_o)
    else $error("decision strobe missing");
  dec_idle_a: assert property (!pkt_valid_i |=> !dec_valid_o &&
    $stable(dec_drop_o) && $stable(dec_src_o))
    else $error("decision moved without descriptor");
  mc_filter_a: assert property (pkt_valid_i &&
    glob_q[SIRF_G_FILT_MC] &&
    pkt_da_mc_i && !pkt_da_bc_i && !pkt_da_found_i |=> dec_drop_o)
    else $error("unknown multicast passed");
  unk_ucast_a: assert property (pkt_valid_i &&
    glob_q[SIRF_G_DROP_UNK] &&
    !pkt_da_mc_i && !pkt_da_bc_i && !pkt_da_found_i |=> dec_drop_o)
    else $error("unknown unicast passed");
  state_drop_a: assert property (pkt_valid_i && st_w != SIRF_ST_FWD
    |=> dec_drop_o) else $error("non forwarding port passed");
  learn_rule_a: assert property (pkt_valid_i
    |=> dec_learn_o == $past(lrn_w)) else $error("learn decision wrong");
  src_default_a: assert property (pkt_valid_i &&
    !glob_q[SIRF_G_IP_PRIORITY_ENABLE] &&
    !glob_q[SIRF_G_USE_TAG] |=> dec_src_o == SIRF_SRC_DEFAULT)
    else $error("priority source offered while disabled");
  glob_read_a: assert property (reg_rd_i &&
    reg_addr_i == SIRF_IDX_GLOBAL
    |=> reg_rdata_o == {17'h0, $past(glob_q)})
    else $error("global register read wrong");
  rdata_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without read");
endmodule // sirf_filter_properties

// File: dv/sirf_filter_test.sv
`timescale 1ns/1ps
// Register and descriptor sequences with expected decisions
module sirf_filter_test;
  import sirf_pkg::*;
  logic        clk_i, nrst_i, reg_wr_i, reg_rd_i, pkt_valid_i, dec_valid_o;
  logic        pkt_da_mc_i, pkt_da_bc_i, pkt_da_found_i, pkt_tagged_i;
  logic        pkt_vid_zero_i, pkt_ipv4_i, pkt_ipv6_i, dec_drop_o;
  logic        dec_learn_o;
  logic [15:0] reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o;
  logic [1:0]  pkt_port_i;
  logic [2:0]  pkt_egress_i, pkt_vlan_memb_i, pkt_tag_pri_i, pkt_def_pri_i;
  logic [2:0]  dec_pri_o, dec_src_o;
  logic [7:0]  pkt_tos_i;
  int          error_cnt, n_tests, cyc;
  // Global values and expected {drop, learn, pri, src} for priority test
  logic [31:0] gp[6] = '{32'h204, 32'h200, 32'h4206, 32'h4204, 32'h6,
                         32'h4000};
  logic [7:0]  ep[6] = '{8'h5a, 8'h73, 8'h69, 8'h5a, 8'h48, 8'h69};
  logic [5:0]  fk[3] = '{6'h00, 6'h20, 6'h30}; // Unicast, multicast, bcast
  sirf_filter dut_u (.*);
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // Hang guard; the full run needs well under a thousand cycles
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      error_cnt++;
      final_report();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i    <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    @(posedge clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i   <= 1'b0;
    #1;
    chk(reg_rdata_o, e);
  endtask
  // f is {mc, bc, found, tagged, vid_zero, ipv4}; e the expected decision
  task automatic pk(input logic [1:0] p, input logic [5:0] f,
    input logic [2:0] eg, input logic [2:0] mb, input logic [7:0] e);
    @(posedge clk_i);
    pkt_valid_i <= 1'b1;
    pkt_port_i  <= p;
    {pkt_da_mc_i, pkt_da_bc_i, pkt_da_found_i, pkt_tagged_i,
     pkt_vid_zero_i, pkt_ipv4_i} <= f;
    pkt_egress_i    <= eg;
    pkt_vlan_memb_i <= mb;
    @(posedge clk_i);
    pkt_valid_i <= 1'b0;
    #1;
    chk({31'h0, dec_valid_o}, 32'h1);
    chk({24'h0, dec_drop_o, dec_learn_o, dec_pri_o, dec_src_o}, {24'h0, e});
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    {nrst_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, pkt_valid_i} = '0;
    {pkt_port_i, pkt_da_mc_i, pkt_da_bc_i, pkt_da_found_i} = '0;
    {pkt_egress_i, pkt_vlan_memb_i, pkt_tagged_i, pkt_vid_zero_i} = '0;
    {pkt_ipv4_i, pkt_ipv6_i, error_cnt, n_tests, cyc} = '0;
    pkt_tag_pri_i = 3'h5;
    pkt_def_pri_i = 3'h1;
    pkt_tos_i     = 8'h6c; // Precedence 3, table index 1b
    repeat (10) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(SIRF_IDX_GLOBAL, 32'h6);
    rd(SIRF_IDX_PORT_CFG, 32'h38);
    rd(SIRF_IDX_TAG_ONLY, 32'h0);
    rd(SIRF_IDX_PORT_STATE, 32'h0);
    wr(SIRF_IDX_PORT_CFG, 32'hffffffff);
    rd(SIRF_IDX_PORT_CFG, 32'h3f);
    wr(16'h1850, 32'hffffffff);
    rd(16'h1850, 32'h0);
    wr(SIRF_IDX_PORT_CFG, 32'h38);
    $display("register test done");
    // Every state code on port 2, the top field of the state register
    for (int s = 0; s < 4; s++)
    begin
      wr(SIRF_IDX_PORT_STATE, 32'(s) << 4);
      pk(2'h2, 6'h08, 3'h0, 3'h7, {s != 0, s[0] == 0, 6'h08});
    end
    wr(SIRF_IDX_PORT_STATE, 32'h0);
    wr(SIRF_IDX_PORT_CFG, 32'h18);
    pk(2'h2, 6'h08, 3'h0, 3'h7, 8'h08);
    pk(2'h0, 6'h08, 3'h0, 3'h7, 8'h48);
    wr(SIRF_IDX_PORT_CFG, 32'h38);
    $display("state test done");
    for (int i = 0; i < 3; i++)
    begin
      wr(SIRF_IDX_GLOBAL, 32'h6 | ((32'h4 << i) & 32'h18));
      for (int k = 0; k < 3; k++)
        pk(2'h0, fk[k], 3'h0, 3'h7,
           {(k == 0 && i == 1) || (k == 1 && i == 2), 7'h48});
    end
    $display("address filter test done");
    wr(SIRF_IDX_GLOBAL, 32'h6);
    wr(SIRF_IDX_PORT_CFG, 32'h3f);
    wr(SIRF_IDX_TAG_ONLY, 32'h7);
    pk(2'h1, 6'h08, 3'h1, 3'h0, 8'h48);
    wr(SIRF_IDX_GLOBAL, 32'h7);
    pk(2'h1, 6'h0c, 3'h4, 3'h5, 8'hc8);
    wr(SIRF_IDX_NON_MEMBER, 32'h2);
    pk(2'h1, 6'h0c, 3'h4, 3'h5, 8'h48);
    wr(SIRF_IDX_NON_MEMBER, 32'h0);
    pk(2'h1, 6'h0c, 3'h1, 3'h2, 8'hc8);
    pk(2'h1, 6'h04, 3'h1, 3'h2, 8'h48);
    pk(2'h1, 6'h08, 3'h4, 3'h7, 8'hc8);
    pk(2'h1, 6'h0e, 3'h4, 3'h7, 8'hc8);
    wr(SIRF_IDX_TAG_ONLY, 32'h0);
    wr(SIRF_IDX_PORT_CFG, 32'h38);
    $display("vlan test done");
    wr(SIRF_IDX_DS_INDEX, 32'h1b);
    wr(SIRF_IDX_DS_WDATA, 32'h6);
    rd(SIRF_IDX_DS_RDATA, 32'h6);
    for (int j = 0; j < 6; j++)
    begin
      wr(SIRF_IDX_GLOBAL, gp[j]);
      pk(2'h0, 6'h0d, 3'h0, 3'h7, ep[j]);
    end
    // IPv6 class field goes through the table; source code 4
    wr(SIRF_IDX_GLOBAL, 32'h200);
    pkt_ipv6_i <= 1'b1;
    pk(2'h0, 6'h0c, 3'h0, 3'h7, 8'h74);
    pkt_ipv6_i <= 1'b0;
    $display("priority test done");
    final_report();
  end
endmodule // sirf_filter_test
bind sirf_filter sirf_filter_properties chk_u (.*);

// File: hw/sirf_filter.sv
`timescale 1ns/1ps
// Ingress decision logic: one packet header descriptor in, one decision out.
module sirf_filter
  import sirf_pkg::*;
(
  input  wire logic        clk_i,          // Core clock, 20 MHz
  input  wire logic        nrst_i,         // Async reset, active low
  // Register port
  input  wire logic [15:0] reg_addr_i,     // Register index
  input  wire logic [31:0] reg_wdata_i,    // Write data
  input  wire logic        reg_wr_i,       // Write strobe
  input  wire logic        reg_rd_i,       // Read strobe
  output logic      [31:0] reg_rdata_o,    // Read data, cycle after strobe
  // Packet descriptor, one cycle strobe
  input  wire logic        pkt_valid_i,    // Descriptor present
  input  wire logic [1:0]  pkt_port_i,     // Ingress port 0..2
  input  wire logic        pkt_da_mc_i,    // Destination multicast
  input  wire logic        pkt_da_bc_i,    // Destination broadcast
  input  wire logic        pkt_da_found_i, // Destination in lookup table
  input  wire logic [2:0]  pkt_egress_i,   // Egress map from lookup
  input  wire logic [2:0]  pkt_vlan_memb_i,// Member ports of packet VLAN
  input  wire logic        pkt_tagged_i,   // Carries a VLAN tag
  input  wire logic        pkt_vid_zero_i, // Tag is priority-only
  input  wire logic [2:0]  pkt_tag_pri_i,  // Tag priority
  input  wire logic        pkt_ipv4_i,     // IPv4 packet
  input  wire logic        pkt_ipv6_i,     // IPv6 packet
  input  wire logic [7:0]  pkt_tos_i,      // ToS or traffic class
  input  wire logic [2:0]  pkt_def_pri_i,  // Port default priority
  // Decision, registered, valid one cycle after descriptor
  output logic             dec_valid_o,    // Decision strobe
  output logic             dec_drop_o,     // Packet filtered
  output logic             dec_learn_o,    // Learn source address
  output logic [2:0]       dec_pri_o,      // Receive priority
  output logic [2:0]       dec_src_o       // Priority source code
);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  logic [14:0] glob_q;                     // Global ingress config
  logic [5:0]  port_cfg_q;                 // Learn and membership enables
  logic [2:0]  tag_only_q;                 // Tagged-only admission
  logic [5:0]  state_q;                    // Spanning tree states
  logic [2:0]  non_memb_q;                 // Admit non-member
  logic [5:0]  ds_idx_q;                   // DIFFSERV access index
  logic [2:0]  ds_tbl_q [SIRF_DS_DEPTH];   // DIFFSERV table
  logic        wr_glob;                    // Decoded write enables
  logic        wr_port;
  logic        wr_tago;
  logic        wr_state;
  logic        wr_nmemb;
  logic        wr_ds_idx;
  logic        wr_ds_data;

  assign wr_glob    = reg_wr_i && (reg_addr_i == SIRF_IDX_GLOBAL);
  assign wr_port    = reg_wr_i && (reg_addr_i == SIRF_IDX_PORT_CFG);
  assign wr_tago    = reg_wr_i && (reg_addr_i == SIRF_IDX_TAG_ONLY);
  assign wr_state   = reg_wr_i && (reg_addr_i == SIRF_IDX_PORT_STATE);
  assign wr_nmemb   = reg_wr_i && (reg_addr_i == SIRF_IDX_NON_MEMBER);
  assign wr_ds_idx  = reg_wr_i && (reg_addr_i == SIRF_IDX_DS_INDEX);
  assign wr_ds_data = reg_wr_i && (reg_addr_i == SIRF_IDX_DS_WDATA);

  // Plain configuration writes; bit groups keep port 2 at the top
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      glob_q     <= SIRF_G_RST;
      port_cfg_q <= SIRF_P_RST;
      tag_only_q <= SIRF_TAGO_RST;
      state_q    <= SIRF_STATE_RST;            // All forwarding
      non_memb_q <= SIRF_NMEMB_RST;
      ds_idx_q   <= 6'h00;
    end
    else
    begin
      if (wr_glob)   glob_q     <= reg_wdata_i[14:0];
      if (wr_port)   port_cfg_q <= reg_wdata_i[5:0];
      if (wr_tago)   tag_only_q <= reg_wdata_i[2:0];
      if (wr_state)  state_q    <= reg_wdata_i[5:0];
      if (wr_nmemb)  non_memb_q <= reg_wdata_i[2:0];
      if (wr_ds_idx) ds_idx_q   <= reg_wdata_i[5:0];
    end
  end

  // DIFFSERV table, one flip-flop group per entry
  genvar gi;
  generate
    for (gi = 0; gi < SIRF_DS_DEPTH; gi++)
    begin : g_ds
      always_ff @(posedge clk_i or negedge nrst_i)
      begin
        if (!nrst_i)
          ds_tbl_q[gi] <= SIRF_DS_RST;
        else if (wr_ds_data && (ds_idx_q == 6'(gi)))
          ds_tbl_q[gi] <= reg_wdata_i[2:0];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Read back; unmapped indices and reserved bits read zero
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      reg_rdata_o <= 32'h0000_0000;
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        SIRF_IDX_GLOBAL:     reg_rdata_o <= {17'h0, glob_q};
        SIRF_IDX_PORT_CFG:   reg_rdata_o <= {26'h0, port_cfg_q};
        SIRF_IDX_TAG_ONLY:   reg_rdata_o <= {29'h0, tag_only_q};
        SIRF_IDX_PORT_STATE: reg_rdata_o <= {26'h0, state_q};
        SIRF_IDX_NON_MEMBER: reg_rdata_o <= {29'h0, non_memb_q};
        SIRF_IDX_DS_INDEX:   reg_rdata_o <= {26'h0, ds_idx_q};
        SIRF_IDX_DS_RDATA:   reg_rdata_o <= {29'h0, ds_tbl_q[ds_idx_q]};
        default:             reg_rdata_o <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Filtering decision
  logic [1:0] st_in;                       // Ingress port state
  logic       p_memb_en;                   // Membership check enabled
  logic       p_tag_only;                  // Tagged-only on port
  logic       p_learn_en;                  // Learning enabled
  logic       p_nmemb;                     // Admit non-member
  logic       in_member;                   // Ingress is VLAN member
  logic       eg_bad;                      // Egress port outside VLAN
  logic       drop_mc;
  logic       drop_uc;
  logic       drop_memb;
  logic       drop_tag;
  logic       drop_stp;
  logic       drop_d;
  logic       learn_d;

  // Port index beyond 2 is treated as port 0 to keep selects in range
  logic [1:0] pidx;
  assign pidx = (pkt_port_i > 2'h2) ? 2'h0 : pkt_port_i;

  always_comb
  begin
    st_in      = state_q[2*pidx +: 2];
    p_memb_en  = port_cfg_q[SIRF_P_MEMB_LSB + 32'(pidx)];
    p_learn_en = port_cfg_q[SIRF_P_LEARN_LSB + 32'(pidx)];
    p_tag_only = tag_only_q[pidx];
    p_nmemb    = non_memb_q[pidx];
    in_member  = pkt_vlan_memb_i[pidx];
    eg_bad     = |(pkt_egress_i & ~pkt_vlan_memb_i);
    // Broadcast is exempt from the multicast filter
    drop_mc = glob_q[SIRF_G_FILT_MC] && pkt_da_mc_i && !pkt_da_bc_i
              && !pkt_da_found_i;
    drop_uc = glob_q[SIRF_G_DROP_UNK] && !pkt_da_mc_i
              && !pkt_da_bc_i && !pkt_da_found_i;
    // Per-port VLAN bits only count under the global enable
    drop_memb = glob_q[SIRF_G_VLAN_EN] && p_memb_en
                && ((!in_member && !p_nmemb)
                    || (pkt_da_found_i && eg_bad));
    drop_tag  = glob_q[SIRF_G_VLAN_EN] && p_tag_only
                && (!pkt_tagged_i || pkt_vid_zero_i);
    // Learning is still allowed in the learning state; data is not
    drop_stp  = (st_in != SIRF_ST_FWD);
    drop_d    = drop_mc || drop_uc || drop_memb || drop_tag || drop_stp;
    learn_d   = p_learn_en && ((st_in == SIRF_ST_FWD)
                               || (st_in == SIRF_ST_LEARN));
  end

  ////////////////////////////////////////////////////////////////////////////
  // Priority source selection
  sirf_src_t src_d;                        // Chosen source
  logic [2:0] pri_d;                       // Chosen priority
  logic       ip_ok;                       // IP source offered
  logic       tag_ok;                      // Tag source offered

  always_comb
  begin
    ip_ok  = glob_q[SIRF_G_IP_PRIORITY_ENABLE] && (pkt_ipv4_i || pkt_ipv6_i);
    tag_ok = glob_q[SIRF_G_USE_TAG] && pkt_tagged_i;
    src_d  = SIRF_SRC_DEFAULT;
    if (tag_ok && (glob_q[SIRF_G_TAG_OV_IP] || !ip_ok))
      src_d = SIRF_SRC_TAG;
    else if (ip_ok && pkt_ipv4_i)
      src_d = glob_q[SIRF_G_USE_PREC] ? SIRF_SRC_PREC
                                      : SIRF_SRC_DIFFSERV;
    else if (ip_ok)
      src_d = SIRF_SRC_IPV6;
    case (src_d)
      SIRF_SRC_TAG:      pri_d = pkt_tag_pri_i;
      SIRF_SRC_PREC:     pri_d = pkt_tos_i[7:5];
      SIRF_SRC_DIFFSERV: pri_d = ds_tbl_q[pkt_tos_i[7:2]];
      SIRF_SRC_IPV6:     pri_d = ds_tbl_q[pkt_tos_i[7:2]];
      default:           pri_d = pkt_def_pri_i;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered decision outputs, one cycle after the descriptor
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      dec_valid_o <= 1'b0;
      dec_drop_o  <= 1'b0;
      dec_learn_o <= 1'b0;
      dec_pri_o   <= 3'h0;
      dec_src_o   <= 3'h0;
    end
    else
    begin
      dec_valid_o <= pkt_valid_i;
      if (pkt_valid_i)
      begin
        dec_drop_o  <= drop_d;
        dec_learn_o <= learn_d;
        dec_pri_o   <= pri_d;
        dec_src_o   <= 3'(src_d);
      end
    end
  end

endmodule // sirf_filter
